// ### verilog/oaslo_pkg.sv
// Constants and types for the octal converter serial LVDS output block
`default_nettype none
package oaslo_pkg;
   localparam int WORD_W = 12;
   localparam int HALF_SLOTS = 24;
   localparam int FRAME_HIGH_HALVES = 12;
   localparam int LATENCY_HALF_CYC = 17;
   localparam int PIPE_DEPTH = (LATENCY_HALF_CYC + 1) / 2;
   localparam int ACC_W = 16;
   localparam logic [15:0] PERIOD_RST = 16'hffff;
   localparam logic [6:0] REG_PLL = 7'h00;
   localparam logic [6:0] REG_FMT = 7'h01;
   localparam logic [6:0] REG_LVL = 7'h02;
   localparam logic [6:0] REG_DRV = 7'h03;
   localparam logic [6:0] REG_ICM = 7'h04;
   localparam logic [6:0] REG_CP1 = 7'h07;
   localparam logic [6:0] REG_CP2 = 7'h08;
   localparam logic [6:0] REG_CP3 = 7'h09;
   localparam logic [6:0] REG_SPECIAL = 7'h10;
   localparam logic [7:0] SOFT_RESET_KEY = 8'h5a;
   localparam logic [7:0] RST_PLL = 8'h11;
   localparam logic [7:0] RST_FMT = 8'h00;
   localparam logic [7:0] RST_LVL = 8'h00;
   localparam logic [7:0] RST_DRV = 8'h00;
   localparam logic [7:0] RST_ICM = 8'h08;
   localparam logic [7:0] RST_CP1 = 8'haa;
   localparam logic [7:0] RST_CP2 = 8'h55;
   localparam logic [7:0] RST_CP3 = 8'h5a;
   localparam int PLL_LSB = 4;
   localparam int LVL_CM_LSB = 0;
   localparam int LVL_DATA_LSB = 2;
   localparam int LVL_CLK_LSB = 4;
   localparam int LVL_FRM_LSB = 6;
   localparam int DRV_TERM_LSB = 4;
   localparam int ICM_CLKTERM_BIT = 4;
   localparam int ICM_BIAS_BIT = 5;
   localparam logic [1:0] FORCE_LOW = 2'h1;
   localparam logic [1:0] FORCE_HIGH = 2'h2;
   localparam logic [2:0] TP_OFF = 3'h0;
   localparam logic [2:0] TP_CUSTOM = 3'h1;
   localparam logic [2:0] TP_ALT = 3'h2;
   localparam logic [2:0] TP_RAMP = 3'h3;
   localparam logic [2:0] TP_CHECK = 3'h4;
   localparam logic [11:0] CHECK_A = 12'haaa;
   localparam logic [11:0] CHECK_B = 12'h555;
   typedef struct packed {
      logic spare;
      logic [2:0] tpat;
      logic [1:0] phase;
      logic twos;
      logic msb;
   } oaslo_fmt_t;
   typedef enum logic [1:0] {SPI_IDLE, SPI_ADDR, SPI_DATA, SPI_DONE} oaslo_spi_t;
endpackage
`default_nettype wire

// ### verilog/oaslo_core.sv
// Serial LVDS output side of the octal converter: capture, latency, serializer, config port
// Operation
// - Capture all channels on sample clock rise
// - Output word 8.5 input cycles after sampling
// - Forwarded bit clock at six times sample
// - Data changes on both bit clock edges
// - Frame rising edge marks first word bit
// - Frame rises once per sample clock
// - Default LSB first, offset binary
// - Format register selects MSB first, twos
// - Format register shifts bit clock phase
// - Output common-mode code, default 1.2V
// - Driver current code, default 3.5mA
// - Output termination off by default, selectable
// - Lanes, clock, frame forceable static
// - Test patterns, custom from three registers
// - Input common-mode code, default 1.100V
// - Internal input bias off by default
// - One bit switches clock input termination
// - PLL range resets to 39-50MHz setting
// - Grounded negative input selects single-ended clock
// - Three-bit PLL field, default code 001
`timescale 1ns/1ps
`default_nettype none
module oaslo_core #(
   parameter int NCH = 8
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clkDiffIn,
   input wire logic clkSeIn,
   input wire logic clkNegLowIn,
   input wire logic [NCH-1:0][oaslo_pkg::WORD_W-1:0] convData,
   input wire logic spiCsN,
   input wire logic spiSclk,
   input wire logic sdioIn,
   output logic sdioOut,
   output logic sdioOe,
   output logic [NCH-1:0] laneOut,
   output logic forwardedBitClock,
   output logic frameOut,
   output logic diffClkRxEn,
   output logic [2:0] pllRange,
   output logic [1:0] outCmCode,
   output logic [3:0] driveCurrent,
   output logic [2:0] outTermSel,
   output logic [3:0] inCmCode,
   output logic inBiasInternal,
   output logic clkInTermEn
);
   import oaslo_pkg::*;
   localparam int SW = NCH * WORD_W + 6;
   localparam int HW = 5;
   localparam logic [HW-1:0] LAST_HALF = HW'(HALF_SLOTS - 1);

   logic [SW-1:0] meta_q;
   logic [SW-1:0] sync_q;
   logic sampD_q;
   logic sclkD_q;
   logic seMode;
   logic sampClk;
   logic csN;
   logic sclk;
   logic sdio;
   logic sampRise;
   logic sampFall;
   logic sclkRise;
   logic sclkFall;
   logic [NCH-1:0][WORD_W-1:0] convS;

   // Pins and the converter word are both outside this clock, so all go through two flops
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         sync_q <= '0;
         sampD_q <= 1'b0;
         sclkD_q <= 1'b0;
      end
      else
      begin
         meta_q <= {convData, sdioIn, spiSclk, spiCsN, clkNegLowIn, clkSeIn, clkDiffIn};
         sync_q <= meta_q;
         sampD_q <= sampClk;
         sclkD_q <= sclk;
      end
   end

   assign seMode = sync_q[2];
   assign sampClk = seMode ? sync_q[1] : sync_q[0];
   assign csN = sync_q[3];
   assign sclk = sync_q[4];
   assign sdio = sync_q[5];
   assign convS = sync_q[SW-1:6];
   assign sampRise = sampClk & ~sampD_q;
   assign sampFall = ~sampClk & sampD_q;
   assign sclkRise = sclk & ~sclkD_q;
   assign sclkFall = ~sclk & sclkD_q;

   logic [7:0] pll_q, pll_d, lvl_q, lvl_d, drv_q, drv_d, icm_q, icm_d;
   logic [7:0] cp1_q, cp1_d, cp2_q, cp2_d, cp3_q, cp3_d;
   oaslo_fmt_t fmt_q, fmt_d;
   oaslo_spi_t spi_q, spi_d;
   logic [2:0] bit_q, bit_d;
   logic [7:0] shr_q, shr_d;
   logic rd_q, rd_d;
   logic [6:0] addr_q, addr_d;
   logic [6:0] addrNew;
   logic sdo_d, oe_d, wrEn;
   logic [7:0] wData, rData;

   assign addrNew = {shr_q[5:0], sdio};
   assign wData = {shr_q[6:0], sdio};

   always_comb
   begin
      case (addrNew)
         REG_PLL: rData = pll_q;
         REG_FMT: rData = fmt_q;
         REG_LVL: rData = lvl_q;
         REG_DRV: rData = drv_q;
         REG_ICM: rData = icm_q;
         REG_CP1: rData = cp1_q;
         REG_CP2: rData = cp2_q;
         REG_CP3: rData = cp3_q;
         default: rData = 8'h00;
      endcase
   end

   // Two-byte frame: read flag and address, then data, MSB first both ways
   always_comb
   begin
      spi_d = spi_q;
      bit_d = bit_q;
      shr_d = shr_q;
      rd_d = rd_q;
      addr_d = addr_q;
      sdo_d = sdioOut;
      oe_d = sdioOe;
      wrEn = 1'b0;
      case (spi_q)
         SPI_IDLE:
         begin
            spi_d = SPI_ADDR;
            bit_d = 3'h0;
         end
         SPI_ADDR:
            if (sclkRise)
            begin
               shr_d = wData;
               bit_d = bit_q + 3'h1;
               if (bit_q == 3'h7)
               begin
                  rd_d = shr_q[6];
                  addr_d = addrNew;
                  shr_d = rData;
                  spi_d = SPI_DATA;
               end
            end
         SPI_DATA:
         begin
            if (rd_q && sclkFall)
            begin
               sdo_d = shr_q[7];
               oe_d = 1'b1;
               shr_d = {shr_q[6:0], 1'b0};
            end
            if (sclkRise)
            begin
               bit_d = bit_q + 3'h1;
               if (!rd_q)
                  shr_d = wData;
               if (bit_q == 3'h7)
               begin
                  wrEn = !rd_q;
                  spi_d = SPI_DONE;
               end
            end
         end
         default: oe_d = 1'b0;
      endcase
      // A deselect aborts any frame; a new frame needs chip select high first
      if (csN)
      begin
         spi_d = SPI_IDLE;
         oe_d = 1'b0;
      end
   end

   always_comb
   begin
      pll_d = pll_q;
      fmt_d = fmt_q;
      lvl_d = lvl_q;
      drv_d = drv_q;
      icm_d = icm_q;
      cp1_d = cp1_q;
      cp2_d = cp2_q;
      cp3_d = cp3_q;
      if (wrEn)
      begin
         case (addr_q)
            REG_PLL: pll_d = wData;
            REG_FMT: fmt_d = oaslo_fmt_t'(wData);
            REG_LVL: lvl_d = wData;
            REG_DRV: drv_d = wData;
            REG_ICM: icm_d = wData;
            REG_CP1: cp1_d = wData;
            REG_CP2: cp2_d = wData;
            REG_CP3: cp3_d = wData;
            REG_SPECIAL:
               if (wData == SOFT_RESET_KEY)
               begin
                  pll_d = RST_PLL;
                  fmt_d = oaslo_fmt_t'(RST_FMT);
                  lvl_d = RST_LVL;
                  drv_d = RST_DRV;
                  icm_d = RST_ICM;
                  cp1_d = RST_CP1;
                  cp2_d = RST_CP2;
                  cp3_d = RST_CP3;
               end
            default: ;
         endcase
      end
   end

   assign pllRange = pll_q[PLL_LSB +: 3];
   assign outCmCode = lvl_q[LVL_CM_LSB +: 2];
   assign driveCurrent = drv_q[3:0];
   assign outTermSel = drv_q[DRV_TERM_LSB +: 3];
   assign inCmCode = icm_q[3:0];
   assign inBiasInternal = icm_q[ICM_BIAS_BIT];
   assign clkInTermEn = icm_q[ICM_CLKTERM_BIT];

   // Bit timing: period measured between falling sample edges, split in 24 half slots.
   // The estimate lags by one period, so a changing input clock costs a frame or two.
   logic [ACC_W-1:0] per_q, per_d, perCnt_q, perCnt_d, acc_q, acc_d;
   logic [ACC_W:0] accSum;
   logic [HW-1:0] half_q, half_d;
   logic stable_q, stable_d;
   logic [WORD_W-1:0] frm_q, frm_d;

   always_comb
   begin
      per_d = per_q;
      perCnt_d = (&perCnt_q) ? perCnt_q : perCnt_q + 16'h1;
      accSum = {1'b0, acc_q} + 17'(HALF_SLOTS);
      acc_d = acc_q;
      half_d = half_q;
      stable_d = stable_q;
      frm_d = frm_q;
      if (sampFall)
      begin
         per_d = perCnt_d;
         stable_d = (perCnt_d == per_q);
         perCnt_d = '0;
         acc_d = '0;
         half_d = '0;
         frm_d = frm_q + 12'h1;
      end
      else if (half_q != LAST_HALF)
      begin
         if (accSum >= {1'b0, per_q})
         begin
            acc_d = ACC_W'(accSum - {1'b0, per_q});
            half_d = half_q + 5'h1;
         end
         else
            acc_d = ACC_W'(accSum);
      end
   end

   function automatic logic forceLvl(input logic v, input logic [1:0] code);
      case (code)
         FORCE_LOW: return 1'b0;
         FORCE_HIGH: return 1'b1;
         default: return v;
      endcase
   endfunction

   logic [NCH-1:0][WORD_W-1:0] pipe_q [PIPE_DEPTH];
   logic [NCH-1:0][WORD_W-1:0] pipe_d [PIPE_DEPTH];
   logic [NCH-1:0][WORD_W-1:0] word_q, word_d;
   logic [NCH-1:0] lane_d;
   logic fbc_d, frame_d;
   logic [HW-1:0] phSum;
   logic [3:0] idx, outIdx_q;
   logic [4:0] tog_q, tog_d;
   logic cfgHeld_q, cfgHeld_d;
   logic [WORD_W-1:0] patA, patB;
   assign patA = {cp2_q[3:0], cp1_q};
   assign patB = {cp3_q, cp2_q[7:4]};
   // A phase or clock force change inside a frame legally bends its edge count
   assign cfgHeld_d = (sampFall || cfgHeld_q)
      && {fmt_d, lvl_d[LVL_CLK_LSB +: 2]} == {fmt_q, lvl_q[LVL_CLK_LSB +: 2]};

   always_comb
   begin
      logic [WORD_W-1:0] w;
      w = '0;
      pipe_d = pipe_q;
      word_d = word_q;
      if (sampRise)
      begin
         pipe_d[0] = convS;
         for (int i = 1; i < PIPE_DEPTH; i++)
            pipe_d[i] = pipe_q[i-1];
      end
      idx = half_d[HW-1:1];
      phSum = half_d + HW'(fmt_q.phase);
      fbc_d = forceLvl(phSum[1], lvl_q[LVL_CLK_LSB +: 2]);
      frame_d = forceLvl(half_d < HW'(FRAME_HIGH_HALVES), lvl_q[LVL_FRM_LSB +: 2]);
      for (int c = 0; c < NCH; c++)
      begin
         // twos complement flips the sign bit
         w = pipe_q[PIPE_DEPTH-1][c] ^ {fmt_q.twos, {(WORD_W-1){1'b0}}};
         case (fmt_q.tpat)
            TP_CUSTOM: w = patA;
            TP_ALT: w = frm_q[0] ? patB : patA;
            TP_RAMP: w = frm_q;
            TP_CHECK: w = frm_q[0] ? CHECK_B : CHECK_A;
            default: ;
         endcase
         // oldest stage leaves half a cycle later
         if (sampFall)
            word_d[c] = w;
         lane_d[c] = fmt_q.msb ? word_d[c][4'(WORD_W-1) - idx] : word_d[c][idx];
         lane_d[c] = forceLvl(lane_d[c], lvl_q[LVL_DATA_LSB +: 2]);
      end
      tog_d = sampFall ? 5'h0 : tog_q + 5'(fbc_d != forwardedBitClock);
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pll_q <= RST_PLL;
         fmt_q <= oaslo_fmt_t'(RST_FMT);
         lvl_q <= RST_LVL;
         drv_q <= RST_DRV;
         icm_q <= RST_ICM;
         cp1_q <= RST_CP1;
         cp2_q <= RST_CP2;
         cp3_q <= RST_CP3;
         spi_q <= SPI_IDLE;
         bit_q <= 3'h0;
         shr_q <= 8'h00;
         rd_q <= 1'b0;
         addr_q <= 7'h00;
         sdioOut <= 1'b0;
         sdioOe <= 1'b0;
         per_q <= PERIOD_RST;
         perCnt_q <= '0;
         acc_q <= '0;
         half_q <= '0;
         stable_q <= 1'b0;
         frm_q <= '0;
         pipe_q <= '{default: '0};
         word_q <= '0;
         laneOut <= '0;
         forwardedBitClock <= 1'b0;
         frameOut <= 1'b0;
         diffClkRxEn <= 1'b1;
         outIdx_q <= 4'h0;
         tog_q <= 5'h0;
         cfgHeld_q <= 1'b0;
      end
      else
      begin
         pll_q <= pll_d;
         fmt_q <= fmt_d;
         lvl_q <= lvl_d;
         drv_q <= drv_d;
         icm_q <= icm_d;
         cp1_q <= cp1_d;
         cp2_q <= cp2_d;
         cp3_q <= cp3_d;
         spi_q <= spi_d;
         bit_q <= bit_d;
         shr_q <= shr_d;
         rd_q <= rd_d;
         addr_q <= addr_d;
         sdioOut <= sdo_d;
         sdioOe <= oe_d;
         per_q <= per_d;
         perCnt_q <= perCnt_d;
         acc_q <= acc_d;
         half_q <= half_d;
         stable_q <= stable_d;
         frm_q <= frm_d;
         pipe_q <= pipe_d;
         word_q <= word_d;
         laneOut <= lane_d;
         forwardedBitClock <= fbc_d;
         frameOut <= frame_d;
         diffClkRxEn <= ~seMode;
         outIdx_q <= idx;
         tog_q <= tog_d;
         cfgHeld_q <= cfgHeld_d;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence sFrameStart;
      sampFall ##1 $rose(frameOut);
   endsequence
   sequence sSoftReset;
      wrEn && addr_q == REG_SPECIAL && wData == SOFT_RESET_KEY;
   endsequence

   AST_CAPTURE: assert property (sampRise |=> pipe_q[0] == $past(convS))
      else $error("sample not captured on rising edge");
   AST_LATENCY: assert property (sampFall && fmt_q.tpat == TP_OFF |=>
      word_q[0] == ($past(pipe_q[PIPE_DEPTH-1][0]) ^ {$past(fmt_q.twos), {(WORD_W-1){1'b0}}}))
      else $error("frame word is not the delayed sample");
   AST_TWELVE_EDGES: assert property (sampFall && stable_q && lvl_q[LVL_CLK_LSB +: 2] == 2'h0
      && cfgHeld_q |-> tog_q + 5'(fbc_d != forwardedBitClock) == 5'(HALF_SLOTS / 2))
      else $error("bit clock edge count per frame wrong");
   AST_FRAME_ALIGN: assert property ($rose(frameOut) && lvl_q[LVL_FRM_LSB +: 2] == 2'h0 |-> outIdx_q == 4'h0)
      else $error("frame rise not on first bit");
   AST_FRAME_RATE: assert property (sampFall && stable_q && lvl_q[LVL_FRM_LSB +: 2] == 2'h0
      && $past(lvl_q[LVL_FRM_LSB +: 2]) == 2'h0 |-> sFrameStart)
      else $error("frame missing for sample period");
   AST_LSB_FIRST: assert property (sampFall && !fmt_q.msb && lvl_q[LVL_DATA_LSB +: 2] == 2'h0 |=>
      laneOut[0] == word_q[0][0])
      else $error("first bit is not the LSB");
   AST_MSB_FIRST: assert property (sampFall && fmt_q.msb && lvl_q[LVL_DATA_LSB +: 2] == 2'h0 |=>
      laneOut[NCH-1] == word_q[NCH-1][WORD_W-1])
      else $error("first bit is not the MSB");
   AST_PHASE: assert property (sampFall && lvl_q[LVL_CLK_LSB +: 2] == 2'h0 |=>
      forwardedBitClock == $past(fmt_q.phase[1]))
      else $error("bit clock phase at frame start wrong");
   AST_FORCE: assert property (lvl_q[LVL_DATA_LSB +: 2] == FORCE_HIGH |=> &laneOut)
      else $error("forced high lanes not high");
   AST_PATTERN: assert property (sampFall && fmt_q.tpat == TP_CUSTOM |=> word_q[NCH-1] == $past(patA))
      else $error("custom pattern word wrong");
   AST_SE_MODE: assert property (seMode [*2] |-> !diffClkRxEn)
      else $error("differential receiver left on");
   AST_SOFT_RESET: assert property (sSoftReset |=> pllRange == RST_PLL[PLL_LSB +: 3] && !clkInTermEn)
      else $error("soft reset left settings");
endmodule // oaslo_core
`default_nettype wire

// ### bench/oaslo_rx_model.sv
// Receiver model that deserializes the eight lanes on every bit clock edge
`timescale 1ns/1ps
`default_nettype none
module oaslo_rx_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] laneOut,
   input wire logic bitClk,
   input wire logic frameIn,
   output logic [7:0][11:0] rxWord,
   output logic rxValid,
   output logic [4:0] edgeCnt,
   output logic [7:0] framePeriod,
   output logic clkAtFrame
);
   logic bitClkQ, frameQ, rise, edgeSeen;
   logic [4:0] idx, edges, bitPos;
   logic [7:0] per;
   logic [7:0][11:0] shiftQ;
   assign rise = frameIn & ~frameQ;
   assign edgeSeen = bitClk ^ bitClkQ;
   // Word position restarts at the frame rise, so a missing or extra edge shows up as a bad word
   assign bitPos = rise ? 5'h0 : idx;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bitClkQ <= 1'b0;
         frameQ <= 1'b0;
         rxValid <= 1'b0;
         per <= 8'h0;
         idx <= 5'h0;
         edges <= 5'h0;
         edgeCnt <= 5'h0;
         framePeriod <= 8'h0;
         clkAtFrame <= 1'b0;
         shiftQ <= '0;
         rxWord <= '0;
      end
      else
      begin
         bitClkQ <= bitClk;
         frameQ <= frameIn;
         rxValid <= 1'b0;
         per <= rise ? 8'h1 : per + 8'h1;
         idx <= bitPos + {4'h0, edgeSeen};
         edges <= (rise ? 5'h0 : edges) + {4'h0, edgeSeen};
         if (rise)
         begin
            edgeCnt <= edges;
            framePeriod <= per;
            clkAtFrame <= bitClk;
         end
         if (edgeSeen && bitPos < 5'd12)
         begin
            for (int c = 0; c < 8; c++)
               shiftQ[c][bitPos] <= laneOut[c];
            if (bitPos == 5'd11)
            begin
               for (int c = 0; c < 8; c++)
                  rxWord[c] <= {laneOut[c], shiftQ[c][10:0]};
               rxValid <= 1'b1;
            end
         end
      end
   end
endmodule // oaslo_rx_model
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the serial LVDS output block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin fails++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
   import oaslo_pkg::*;
   logic sys_clk = 0, rst_n = 0, smp = 0, seMode = 0, clkNegLowIn = 0;
   logic spiCsN = 1, spiSclk = 0, tbOe = 0, tbBit = 0, lastBit = 0;
   logic [7:0][11:0] convData = '0;
   wire logic clkDiffIn, clkSeIn, sdio;
   logic sdioOut, sdioOe, forwardedBitClock, frameOut, diffClkRxEn, inBiasInternal, clkInTermEn;
   logic [7:0] laneOut;
   logic [2:0] pllRange, outTermSel;
   logic [1:0] outCmCode;
   logic [3:0] driveCurrent, inCmCode;
   logic [7:0][11:0] rxWord;
   logic rxValid, clkAtFrame, ok;
   logic [4:0] edgeCnt;
   logic [7:0] framePeriod;
   logic [11:0] w, prevW, pA, pB;
   int fails = 0, n_checks = 0, sIdx = 0, expIdx = 0, wordIdx = 0;
   logic [6:0] ra [8] = '{REG_PLL, REG_FMT, REG_LVL, REG_DRV, REG_ICM, REG_CP1, REG_CP2, REG_CP3};
   logic [7:0] rv [8] = '{RST_PLL, RST_FMT, RST_LVL, RST_DRV, RST_ICM, RST_CP1, RST_CP2, RST_CP3};
   logic [7:0] cp [3] = '{8'h34, 8'h9c, 8'h6e};
   logic [7:0] lv [2] = '{8'h64, 8'h98};

   assign clkDiffIn = smp & ~seMode;
   assign clkSeIn = smp & seMode;
   // Undriven data line flips every cycle so a read never matches by luck
   assign sdio = sdioOe ? sdioOut : (tbOe ? tbBit : ~lastBit);
   always @(posedge sys_clk) lastBit <= sdio;
   always #2 sys_clk = ~sys_clk;
   initial
   begin
      #1;
      forever #80 smp = ~smp;
   end
   // New sample values appear mid-period, well away from the capture edge
   always @(negedge smp)
   begin
      sIdx++;
      for (int c = 0; c < 8; c++)
         convData[c] <= v(sIdx, c);
   end
   always @(posedge frameOut) expIdx = sIdx - 9;

   oaslo_core i_oaslo_core (.sys_clk(sys_clk), .rst_n(rst_n), .clkDiffIn(clkDiffIn), .clkSeIn(clkSeIn),
      .clkNegLowIn(clkNegLowIn), .convData(convData), .spiCsN(spiCsN), .spiSclk(spiSclk), .sdioIn(sdio),
      .sdioOut(sdioOut), .sdioOe(sdioOe), .laneOut(laneOut), .forwardedBitClock(forwardedBitClock),
      .frameOut(frameOut), .diffClkRxEn(diffClkRxEn), .pllRange(pllRange), .outCmCode(outCmCode),
      .driveCurrent(driveCurrent), .outTermSel(outTermSel), .inCmCode(inCmCode),
      .inBiasInternal(inBiasInternal), .clkInTermEn(clkInTermEn));
   oaslo_rx_model i_oaslo_rx_model (.sys_clk(sys_clk), .rst_n(rst_n), .laneOut(laneOut),
      .bitClk(forwardedBitClock), .frameIn(frameOut), .rxWord(rxWord), .rxValid(rxValid),
      .edgeCnt(edgeCnt), .framePeriod(framePeriod), .clkAtFrame(clkAtFrame));

   function automatic logic [11:0] v(input int k, input int c);
      return 12'(k * 16 + c * 3);
   endfunction
   function automatic logic [11:0] fmtw(input logic [11:0] d, input logic [7:0] f);
      logic [11:0] r;
      r = f[1] ? {~d[11], d[10:0]} : d;
      fmtw = r;
      if (f[0])
      begin
         for (int i = 0; i < 12; i++)
            fmtw[i] = r[11 - i];
      end
   endfunction
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic wrap_up();
      $display("Checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic done(input string s);
      $display("Test %s finished", s);
   endtask
   task automatic spi(input logic rw, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
      logic [15:0] f;
      f = {rw, a, d};
      q = 8'h00;
      spiCsN = 0;
      tick(4);
      for (int i = 15; i >= 0; i--)
      begin
         tbOe = !(rw && i < 8);
         tbBit = f[i];
         tick(8);
         if (rw && i < 8)
            q[i] = sdio;
         spiSclk = 1;
         tick(8);
         spiSclk = 0;
      end
      tick(8);
      spiCsN = 1;
      tbOe = 0;
      tick(8);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] q;
      spi(1'b0, a, d, q);
   endtask
   task automatic rchk(input logic [6:0] a, input logic [7:0] e);
      logic [7:0] q;
      spi(1'b1, a, 8'h00, q);
      `CHK("register", e, q)
   endtask
   task automatic next_word();
      int n;
      n = 0;
      while (rxValid !== 1'b1 && n < 400)
      begin
         // Late clock phases end a word as the next frame rises
         wordIdx = expIdx;
         tick(1);
         n++;
      end
      if (n == 400)
      begin
         $display("Error no word seen");
         fails++;
         wrap_up();
      end
      else
         tick(1);
   endtask
   task automatic skip(input int n);
      repeat (n) next_word();
   endtask
   task automatic chk_conv(input int n, input logic [7:0] f);
      logic [7:0][11:0] e;
      repeat (n)
      begin
         next_word();
         for (int c = 0; c < 8; c++)
            e[c] = fmtw(v(wordIdx, c), f);
         `CHK("lanes", e, rxWord)
         `CHK("edges", 5'd12, edgeCnt)
         `CHK("period", 8'd40, framePeriod)
      end
   endtask
   task automatic chk_defaults();
      for (int j = 0; j < 8; j++)
         rchk(ra[j], rv[j]);
      `CHK("config", {3'h1, 2'h0, 4'h0, 3'h0, 4'h8, 2'h0}, {pllRange, outCmCode, driveCurrent, outTermSel, inCmCode, inBiasInternal, clkInTermEn})
      `CHK("rxEn", 1'b1, diffClkRxEn)
   endtask

   initial
   begin
      #400000;
      $display("Error run limit reached");
      fails++;
      wrap_up();
   end
   initial
   begin
      tick(12);
      rst_n = 1;
      tick(8);
      chk_defaults();
      done("defaults");
      skip(3);
      chk_conv(4, 8'h00);
      wr(REG_FMT, 8'h03);
      skip(3);
      chk_conv(3, 8'h03);
      wr(REG_FMT, 8'h04);
      skip(3);
      chk_conv(3, 8'h04);
      `CHK("clkAtFrame", 1'b0, clkAtFrame)
      wr(REG_FMT, 8'h08);
      skip(3);
      `CHK("clkAtFrame", 1'b1, clkAtFrame)
      done("format");
      for (int j = 0; j < 3; j++)
         wr(ra[5 + j], cp[j]);
      pA = {cp[1][3:0], cp[0]};
      pB = {cp[2], cp[1][7:4]};
      // Twos bit is set throughout: patterns must ignore it
      for (int m = 1; m <= 4; m++)
      begin
         wr(REG_FMT, {1'b0, 3'(m), 4'h2});
         skip(3);
         prevW = rxWord[0];
         repeat (3)
         begin
            next_word();
            w = rxWord[0];
            case (3'(m))
               TP_CUSTOM: ok = w === pA;
               TP_ALT: ok = (w === pA || w === pB) && w !== prevW;
               TP_RAMP: ok = w === prevW + 12'h1;
               default: ok = (w === CHECK_A || w === CHECK_B) && w !== prevW;
            endcase
            `CHK("pattern", 1'b1, ok)
            `CHK("lane7", w, rxWord[7])
            prevW = w;
         end
      end
      wr(REG_FMT, {1'b0, TP_CUSTOM, 4'h1});
      skip(3);
      `CHK("pattern msb", fmtw(pA, 8'h01), rxWord[0])
      wr(REG_FMT, 8'h00);
      done("patterns");
      foreach (lv[j])
      begin
         wr(REG_LVL, lv[j]);
         repeat (30)
         begin
            tick(1);
            `CHK("forced lanes", {8{lv[j][3]}}, laneOut)
            `CHK("forced clock", lv[j][5], forwardedBitClock)
            `CHK("forced frame", lv[j][7], frameOut)
         end
      end
      wr(REG_LVL, 8'h00);
      done("static levels");
      seMode = 1;
      clkNegLowIn = 1;
      tick(6);
      `CHK("rxEn", 1'b0, diffClkRxEn)
      skip(3);
      chk_conv(3, 8'h00);
      seMode = 0;
      clkNegLowIn = 0;
      tick(6);
      `CHK("rxEn", 1'b1, diffClkRxEn)
      skip(3);
      done("single ended");
      for (int j = 0; j < 8; j++)
         wr(ra[j], ~rv[j]);
      for (int j = 0; j < 8; j++)
         rchk(ra[j], ~rv[j]);
      `CHK("config", {~RST_PLL[6:4], ~RST_LVL[1:0], ~RST_DRV[3:0], ~RST_DRV[6:4], ~RST_ICM[3:0], ~RST_ICM[5], ~RST_ICM[4]}, {pllRange, outCmCode, driveCurrent, outTermSel, inCmCode, inBiasInternal, clkInTermEn})
      wr(7'h05, 8'h33);
      rchk(7'h05, 8'h00);
      rchk(7'h0a, 8'h00);
      wr(REG_SPECIAL, 8'h11);
      rchk(REG_PLL, ~RST_PLL);
      wr(REG_SPECIAL, SOFT_RESET_KEY);
      chk_defaults();
      wr(REG_ICM, 8'h00);
      rst_n = 0;
      tick(3);
      rst_n = 1;
      tick(8);
      chk_defaults();
      done("registers");
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
